// file: include/input_cond_pkg.sv
// What this block does
// - special-function results use word bits 0-15
// - plain levels at bits 16-31, input 1 at 16
// - bit 16 shows input 1 regardless of enable
// - sample inputs every millisecond, shorter pulses lost
// - five inputs; 1 neg limit, 2 pos, 3 home
// - threshold bit: 0 gives 5 V, 1 gives 24 V
// - enable bit gates special function, not level bits
// - enable bits: neg, pos, home, interlock
// - invert bit selects normally closed, except clock/direction at word bits 0-1 with routing off
// - force enable substitutes software value for input
// - force value supplies the forced input level
// - raw value shows unmodified sampled inputs
// - bit 0 is neg limit, bit 16 full level
// - routing turns on when routing enable written 1
// - enabling routing loads entries matching prior behaviour outside clock/direction mode
// - routing entry n drives word bit n
// - codes: 0, inputs 01-10, Hall, encoder, USB
// - code bit 7 inverts; 80 gives constant 1
// - interlock bit 0 while enabled raises fault
// - interlock acts only with enable bit 3 set
package input_cond_pkg;
    // ------------------------------------------------------------
    // register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 6;
    localparam logic [5:0] IDX_INPUT_WORD = 6'h00;
    localparam logic [5:0] IDX_SF_ENABLE = 6'h01;
    localparam logic [5:0] IDX_INVERT = 6'h02;
    localparam logic [5:0] IDX_FORCE_EN = 6'h03;
    localparam logic [5:0] IDX_FORCE_VAL = 6'h04;
    localparam logic [5:0] IDX_RAW = 6'h05;
    localparam logic [5:0] IDX_THRESHOLD = 6'h06;
    localparam logic [5:0] IDX_ROUTE_EN = 6'h07;
    localparam logic [5:0] IDX_ROUTE_BASE = 6'h08;
    localparam int NUM_ROUTES = 32;
    localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
    // ------------------------------------------------------------
    // input word layout and source codes
    // ------------------------------------------------------------
    localparam int BIT_NEG_LIMIT = 0;
    localparam int BIT_POS_LIMIT = 1;
    localparam int BIT_HOME = 2;
    localparam int BIT_INTERLOCK = 3;
    localparam int LEVEL_BASE = 16;
    localparam int MAX_INPUTS = 16;
    localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
    localparam logic [6:0] SRC_AUX_FIRST = 7'h41;
    localparam logic [6:0] SRC_AUX_LAST = 7'h47;
    localparam int SRC_INV_BIT = 7;
    localparam logic [7:0] SRC_CONST0 = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
endpackage

// file: hdl/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int W = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;

    if (W < 1) begin : g_chk_w
        $error("W must be at least 1");
    end

    // a bit is accepted only once stages two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_out[i];
    end

    // three-stage chain; the first stage feeds only the second
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_out <= '0;
        end else if (clk_en) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_out <= out_d;
        end
    end
endmodule
`default_nettype wire

// file: hdl/digital_input_conditioning.sv
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module digital_input_conditioning
    import input_cond_pkg::*;
#(
    parameter int NUM_INPUTS = 5,
    parameter int TICK_CYCLES = SAMPLE_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [NUM_INPUTS-1:0] phys_in,
    input wire logic [2:0] hall_in,
    input wire logic [2:0] enc_in,
    input wire logic usb_power,
    input wire logic clock_dir_mode,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [31:0] input_word,
    output logic [NUM_INPUTS-1:0] threshold_24v,
    output logic interlock_fault,
    output logic interlock_fault_pulse
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_INPUTS < 1 || NUM_INPUTS > MAX_INPUTS) begin : g_chk_n
        $error("NUM_INPUTS must be 1 to 16");
    end
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_chk_t
        $error("TICK_CYCLES must be 2 to 65536");
    end

    // ------------------------------------------------------------
    // source decode and default routing
    // ------------------------------------------------------------
    function automatic logic src_pick(input logic [7:0] code, input logic [15:0] lv,
                                      input logic [6:0] aux);
        logic b;
        b = 1'b0;
        if (code[6:0] >= SRC_PHYS_FIRST && code[6:0] <= SRC_PHYS_LAST) begin
            b = lv[4'(code[4:0] - 5'h01)];
        end else if (code[6:0] >= SRC_AUX_FIRST && code[6:0] <= SRC_AUX_LAST) begin
            b = aux[3'(code[2:0] - 3'h1)];
        end
        return b ^ code[SRC_INV_BIT];
    endfunction

    // entries that reproduce the non-routed mapping outside clock-direction mode; bit 3 has no source
    function automatic logic [7:0] route_default(input int n);
        logic [7:0] c;
        c = SRC_CONST0;
        if (n >= LEVEL_BASE) begin
            c = 8'(n - LEVEL_BASE + 1);
        end else if (n <= BIT_HOME) begin
            c = 8'(n + 1);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] pin_s;
    logic [6:0] aux_s;
    logic [15:0] tick_cnt_q;
    logic tick;
    logic [31:0] sfe_q;
    logic [31:0] inv_q;
    logic [31:0] force_en_q;
    logic [31:0] force_val_q;
    logic [31:0] raw_q;
    logic [31:0] thr_q;
    logic route_en_q;
    logic [7:0] route_q [NUM_ROUTES];

    // pins cross in through the three-stage filter
    pin_sync3 #(
        .W(NUM_INPUTS + 7)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in({usb_power, enc_in, hall_in, phys_in}),
        .pin_out({aux_s, pin_s})
    );

    // ------------------------------------------------------------
    // sample tick
    // ------------------------------------------------------------
    // changes that come and go between two ticks are never seen
    assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_q <= '0;
        end else if (clk_en) begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // computation chain
    // ------------------------------------------------------------
    logic [15:0] phys16;
    logic [15:0] forced;
    logic [15:0] lvl;
    logic [31:0] routed;
    logic [31:0] word_d;

    genvar i;
    for (i = 0; i < MAX_INPUTS; i++) begin : g_in
        if (i < NUM_INPUTS) begin : g_real
            assign phys16[i] = pin_s[i];
        end else begin : g_none
            assign phys16[i] = 1'b0;
        end
        assign forced[i] = force_en_q[i] ? force_val_q[i] : phys16[i];
        assign lvl[i] = forced[i] ^ inv_q[i];
    end

    // default mapping: level copy high, gated specials low
    for (i = 0; i < 32; i++) begin : g_word
        if (i >= LEVEL_BASE) begin : g_lvl
            // levels ignore enables in either mode
            assign routed[i] = route_en_q ? src_pick(route_q[i], lvl, aux_s)
                                          : lvl[i - LEVEL_BASE];
            assign word_d[i] = routed[i];
        end else if (i <= BIT_HOME) begin : g_sf
            // clock/direction bypass the inversion in clock-direction mode with routing off
            logic base;
            assign base = (clock_dir_mode && i != BIT_HOME) ? forced[i] : lvl[i];
            assign routed[i] = route_en_q ? src_pick(route_q[i], lvl, aux_s) : base;
            assign word_d[i] = routed[i] & sfe_q[i];
        end else if (i == BIT_INTERLOCK) begin : g_lock
            // only routing gives the interlock a source
            assign routed[i] = route_en_q ? src_pick(route_q[i], lvl, aux_s) : 1'b0;
            assign word_d[i] = routed[i] & sfe_q[i];
        end else begin : g_free
            // unassigned special bits carry only routed sources
            assign routed[i] = route_en_q ? src_pick(route_q[i], lvl, aux_s) : 1'b0;
            assign word_d[i] = routed[i];
        end
    end

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic wr_sfe;
    logic wr_inv;
    logic wr_fen;
    logic wr_fval;
    logic wr_thr;
    logic wr_ren;
    logic route_on;
    logic hit_route;
    logic [4:0] route_idx;
    logic [REG_ADDR_W-1:0] route_off;
    logic [31:0] rd_d;

    assign wr_sfe = reg_wr && reg_addr == IDX_SF_ENABLE;
    assign wr_inv = reg_wr && reg_addr == IDX_INVERT;
    assign wr_fen = reg_wr && reg_addr == IDX_FORCE_EN;
    assign wr_fval = reg_wr && reg_addr == IDX_FORCE_VAL;
    assign wr_thr = reg_wr && reg_addr == IDX_THRESHOLD;
    assign wr_ren = reg_wr && reg_addr == IDX_ROUTE_EN;
    assign route_on = wr_ren && reg_wdata[0] && !route_en_q;
    assign route_off = reg_addr - IDX_ROUTE_BASE;
    assign hit_route = reg_addr >= IDX_ROUTE_BASE && route_off < 6'(NUM_ROUTES);
    assign route_idx = route_off[4:0];

    // unmapped words read as zero; write-only effects never occur on read
    assign rd_d = (reg_addr == IDX_INPUT_WORD) ? input_word :
                  (reg_addr == IDX_SF_ENABLE) ? sfe_q :
                  (reg_addr == IDX_INVERT) ? inv_q :
                  (reg_addr == IDX_FORCE_EN) ? force_en_q :
                  (reg_addr == IDX_FORCE_VAL) ? force_val_q :
                  (reg_addr == IDX_RAW) ? raw_q :
                  (reg_addr == IDX_THRESHOLD) ? thr_q :
                  (reg_addr == IDX_ROUTE_EN) ? {31'h0, route_en_q} :
                  hit_route ? {24'h0, route_q[route_idx]} : 32'h0000_0000;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sfe_q <= RST_CONFIG;
            inv_q <= RST_CONFIG;
            force_en_q <= RST_CONFIG;
            force_val_q <= RST_CONFIG;
            thr_q <= RST_CONFIG;
            route_en_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_sfe) sfe_q <= reg_wdata;
            if (wr_inv) inv_q <= reg_wdata;
            if (wr_fen) force_en_q <= reg_wdata;
            if (wr_fval) force_val_q <= reg_wdata;
            if (wr_thr) thr_q <= reg_wdata;
            if (wr_ren) route_en_q <= reg_wdata[0];
        end
    end

    // routing table; turning routing on reloads the plain-mode mapping, without the clock/direction bypass
    for (i = 0; i < NUM_ROUTES; i++) begin : g_route
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                route_q[i] <= route_default(i);
            end else if (clk_en) begin
                if (route_on) begin
                    route_q[i] <= route_default(i);
                end else if (reg_wr && hit_route && route_idx == 5'(i)) begin
                    route_q[i] <= reg_wdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sampled values, outputs
    // ------------------------------------------------------------
    // raw and word update together so they always describe one sample
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            raw_q <= '0;
            input_word <= '0;
            reg_rdata <= '0;
            threshold_24v <= '0;
            interlock_fault <= 1'b0;
            interlock_fault_pulse <= 1'b0;
        end else if (clk_en) begin
            if (tick) begin
                raw_q <= {16'h0000, phys16};
                input_word <= word_d;
            end
            reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
            threshold_24v <= thr_q[NUM_INPUTS-1:0];
            interlock_fault <= sfe_q[BIT_INTERLOCK] && !input_word[BIT_INTERLOCK];
            interlock_fault_pulse <= sfe_q[BIT_INTERLOCK] && !input_word[BIT_INTERLOCK]
                                     && !interlock_fault;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_plain_tick;
        clk_en && tick && !route_en_q;
    endsequence

    sequence s_route_tick;
        clk_en && tick && route_en_q;
    endsequence

    property p_level_bits;
        @(posedge clock) disable iff (sys_rst)
        s_plain_tick |=> input_word[31:16] == $past(lvl);
    endproperty
    a_level_bits: assert property (p_level_bits) else $error("level half wrong");

    property p_low_free;
        @(posedge clock) disable iff (sys_rst)
        s_plain_tick |=> input_word[15:4] == 12'h000;
    endproperty
    a_low_free: assert property (p_low_free) else $error("unused special bits set");

    property p_sf_gate;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && tick) |=> (input_word[3:0] & ~$past(sfe_q[3:0])) == 4'h0;
    endproperty
    a_sf_gate: assert property (p_sf_gate) else $error("disabled special bit set");

    property p_word_on_tick;
        @(posedge clock) disable iff (sys_rst)
        $changed(input_word) |-> $past(tick) && $past(clk_en);
    endproperty
    a_word_on_tick: assert property (p_word_on_tick) else $error("word moved off tick");

    property p_force;
        @(posedge clock) disable iff (sys_rst)
        (s_plain_tick and force_en_q[0] && !inv_q[0]) |=> input_word[16] == $past(force_val_q[0]);
    endproperty
    a_force: assert property (p_force) else $error("force value not used");

    property p_raw;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && tick) |=> raw_q[15:0] == $past(phys16);
    endproperty
    a_raw: assert property (p_raw) else $error("raw value modified");

    property p_route_load;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && route_on) |=> route_en_q && route_q[16] == 8'h01 && route_q[3] == SRC_CONST0;
    endproperty
    a_route_load: assert property (p_route_load) else $error("routing not preloaded");

    property p_route_const1;
        @(posedge clock) disable iff (sys_rst)
        (s_route_tick and route_q[4] == 8'h80) |=> input_word[4];
    endproperty
    a_route_const1: assert property (p_route_const1) else $error("code 80 not one");

    property p_interlock;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && sfe_q[BIT_INTERLOCK] && !input_word[BIT_INTERLOCK]) |=> interlock_fault;
    endproperty
    a_interlock: assert property (p_interlock) else $error("interlock fault missed");

    property p_pulse_level;
        @(posedge clock) disable iff (sys_rst)
        interlock_fault_pulse |-> interlock_fault;
    endproperty
    a_pulse_level: assert property (p_pulse_level) else $error("pulse without fault");

    property p_fault_once;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && interlock_fault_pulse) |=> !interlock_fault_pulse;
    endproperty
    a_fault_once: assert property (p_fault_once) else $error("fault pulse too long");

    property p_no_lock_fault;
        @(posedge clock) disable iff (sys_rst)
        (clk_en && !sfe_q[BIT_INTERLOCK]) |=> !interlock_fault;
    endproperty
    a_no_lock_fault: assert property (p_no_lock_fault) else $error("fault while off");

    property p_threshold;
        @(posedge clock) disable iff (sys_rst)
        clk_en |=> threshold_24v == $past(thr_q[NUM_INPUTS-1:0]);
    endproperty
    a_threshold: assert property (p_threshold) else $error("threshold copy wrong");

    property p_cd_bypass;
        @(posedge clock) disable iff (sys_rst)
        (s_plain_tick and clock_dir_mode) |=> input_word[0] == ($past(forced[0]) & $past(sfe_q[0]));
    endproperty
    a_cd_bypass: assert property (p_cd_bypass) else $error("clock bit inverted");

    property p_route_level;
        @(posedge clock) disable iff (sys_rst)
        (s_route_tick and route_q[16] == 8'h01) |=> input_word[16] == $past(lvl[0]);
    endproperty
    a_route_level: assert property (p_route_level) else $error("routed input 1 wrong");
endmodule
`default_nettype wire

// file: test/input_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// switches and sensors in front of the block; contacts may chatter on a change
module input_source_model (
    input wire logic clock,
    input wire logic slow,
    input wire logic [4:0] want_phys,
    input wire logic [2:0] want_hall,
    input wire logic [2:0] want_enc,
    input wire logic want_usb,
    output logic [4:0] phys_in,
    output logic [2:0] hall_in,
    output logic [2:0] enc_in,
    output logic usb_power
);
    logic [4:0] cur_q = 5'h00;
    logic [4:0] prev_q = 5'h00;
    logic [3:0] bounce_q = 4'h0;
    // --------------------------------------------------------
    // contact chatter
    // --------------------------------------------------------
    // a slow contact flips between old and new level for a few cycles,
    // far shorter than the sample period, so it must never be seen
    always @(posedge clock) begin
        if (want_phys !== cur_q) begin
            prev_q <= cur_q;
            cur_q <= want_phys;
            bounce_q <= slow ? 4'h6 : 4'h0;
        end else if (bounce_q != 4'h0) begin
            bounce_q <= bounce_q - 4'h1;
        end
    end
    assign phys_in = bounce_q[0] ? prev_q : cur_q;
    // sensors are clean logic levels
    assign hall_in = want_hall;
    assign enc_in = want_enc;
    assign usb_power = want_usb;
endmodule
`default_nettype wire

// file: test/digital_input_conditioning_tb.sv
`timescale 1ns/1ps
`default_nettype none
module digital_input_conditioning_tb;
    import input_cond_pkg::*;
    localparam int TICK = 20;
    logic clock, sys_rst, clk_en, clock_dir_mode, reg_wr, reg_rd, slow, rd_d, want_usb, usb_power;
    logic interlock_fault, interlock_fault_pulse;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, input_word, prev_word, e, sfe, inv, fen, fval;
    logic [4:0] want_phys, phys_in, threshold_24v;
    logic [2:0] want_hall, want_enc, hall_in, enc_in;
    int errors, tests_run, cyc, last_chg, pulse_cnt;
    logic [31:0] exp_q[$];
    logic [7:0] base [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h41,
                              8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};

    input_source_model src (.clock(clock), .slow(slow), .want_phys(want_phys),
        .want_hall(want_hall), .want_enc(want_enc), .want_usb(want_usb), .phys_in(phys_in),
        .hall_in(hall_in), .enc_in(enc_in), .usb_power(usb_power));
    digital_input_conditioning #(.NUM_INPUTS(5), .TICK_CYCLES(TICK)) DUT (.clock(clock),
        .sys_rst(sys_rst), .clk_en(clk_en), .phys_in(phys_in), .hall_in(hall_in),
        .enc_in(enc_in), .usb_power(usb_power), .clock_dir_mode(clock_dir_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .input_word(input_word), .threshold_24v(threshold_24v),
        .interlock_fault(interlock_fault), .interlock_fault_pulse(interlock_fault_pulse));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] ev, input logic [31:0] gv);
        tests_run++;
        if (gv !== ev) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, ev, gv);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= idx;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // the expected read value is queued; the monitor pairs it with the answer
    task automatic rd(input logic [5:0] idx, input logic [31:0] ev);
        @(posedge clock);
        reg_addr <= idx;
        reg_rd <= 1'b1;
        exp_q.push_back(ev);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    // two full sample periods and ten cycles: filter delay plus one whole tick of margin
    task automatic settle;
        repeat (2 * TICK + 10) @(posedge clock);
    endtask
    function automatic logic [31:0] exp_norm(logic [4:0] p, logic [31:0] s, logic [31:0] i,
                                             logic [31:0] fe, logic [31:0] fv);
        logic [4:0] v;
        v = ((p & ~fe[4:0]) | (fv[4:0] & fe[4:0])) ^ i[4:0];
        return {11'h000, v, 13'h0000, v[2:0] & s[2:0]};
    endfunction
    function automatic logic src_val(logic [7:0] c);
        logic v;
        v = 1'b0;
        if (c[6:0] >= 7'h01 && c[6:0] <= 7'h05) v = want_phys[c[2:0] - 3'h1];
        else if (c[6:0] >= 7'h41 && c[6:0] <= 7'h43) v = want_hall[c[2:0] - 3'h1];
        else if (c[6:0] >= 7'h44 && c[6:0] <= 7'h46) v = want_enc[c[2:0] - 3'h4];
        else if (c[6:0] == 7'h47) v = want_usb;
        return v ^ c[7];
    endfunction
    // --------------------------------------------------------
    // monitor: read answers, update spacing, fault pulses, timeout
    // --------------------------------------------------------
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        if (interlock_fault_pulse === 1'b1) pulse_cnt++;
        if (!sys_rst && clk_en) begin
            cyc++;
            if (input_word !== prev_word) begin
                if (last_chg > 0) chk("update_spacing", 0, 32'((cyc - last_chg) % TICK));
                last_chg = cyc;
                prev_word = input_word;
            end
        end
        if (cyc > 30000) begin
            errors++;
            tally_and_finish;
        end
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        {sys_rst, clk_en, clock_dir_mode, reg_wr, reg_rd, slow, want_usb} = 7'h60;
        {reg_addr, reg_wdata, prev_word, want_phys, want_hall, want_enc} = '0;
        {errors, tests_run, cyc, last_chg, pulse_cnt} = '0;
        void'($urandom(49));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        // reset values; routing table holds the plain mapping
        for (int i = 1; i < 41; i++) begin
            e = 32'((i >= 8 && i <= 10) ? i - 7 : (i >= 24 && i <= 39) ? i - 23 : 0);
            rd(6'(i), e);
        end
        // read-only and unmapped places ignore writes
        wr(6'h05, 32'hffff_ffff);
        wr(6'h28, 32'hffff_ffff);
        rd(6'h05, 32'h0000_0000);
        rd(6'h28, 32'h0000_0000);
        // a write with the clock enable low is not taken
        clk_en <= 1'b0;
        wr(IDX_SF_ENABLE, 32'h0000_000f);
        clk_en <= 1'b1;
        rd(IDX_SF_ENABLE, 32'h0000_0000);
        // random force, invert, enable and pin levels in plain mode
        for (int r = 0; r < 8; r++) begin
            sfe = $urandom & 32'h7;
            inv = $urandom & 32'h1f;
            fen = $urandom & 32'h1f;
            fval = $urandom & 32'h1f;
            wr(IDX_SF_ENABLE, sfe);
            wr(IDX_INVERT, inv);
            wr(IDX_FORCE_EN, fen);
            wr(IDX_FORCE_VAL, fval);
            slow <= r[0];
            want_phys <= 5'($urandom);
            settle;
            rd(IDX_INPUT_WORD, exp_norm(want_phys, sfe, inv, fen, fval));
            rd(IDX_RAW, {27'h0000000, want_phys});
        end
        slow <= 1'b0;
        // clock and direction bits ignore inversion but still take forcing
        wr(IDX_SF_ENABLE, 32'h0000_0007);
        wr(IDX_INVERT, 32'h0000_001f);
        wr(IDX_FORCE_EN, 32'h0000_0003);
        wr(IDX_FORCE_VAL, 32'h0000_0001);
        want_phys <= 5'h16;
        clock_dir_mode <= 1'b1;
        settle;
        e = exp_norm(5'h16, 32'h7, 32'h1f, 32'h3, 32'h1);
        e[1:0] = 2'b01;
        rd(IDX_INPUT_WORD, e);
        clock_dir_mode <= 1'b0;
        // threshold selection per input
        wr(IDX_THRESHOLD, 32'h0000_0015);
        repeat (2) @(posedge clock);
        chk("threshold_24v", 32'h0000_0015, {27'h0000000, threshold_24v});
        rd(IDX_THRESHOLD, 32'h0000_0015);
        // a pulse between two samples never reaches the word
        wr(IDX_INVERT, 32'h0);
        wr(IDX_FORCE_EN, 32'h0);
        wr(IDX_SF_ENABLE, 32'h0);
        want_phys <= 5'h00;
        settle;
        want_phys <= 5'h01;
        @(input_word);
        repeat (4) @(posedge clock);
        want_phys <= 5'h03;
        repeat (5) @(posedge clock);
        want_phys <= 5'h01;
        settle;
        rd(IDX_INPUT_WORD, 32'h0001_0000);
        // routing keeps the previous behaviour, then source codes 00-05 and 41-47, plain and inverted
        wr(IDX_SF_ENABLE, 32'h0000_0007);
        want_phys <= 5'h16;
        want_hall <= 3'b101;
        want_enc <= 3'b010;
        want_usb <= 1'b1;
        wr(IDX_ROUTE_EN, 32'h0000_0001);
        settle;
        rd(IDX_INPUT_WORD, exp_norm(5'h16, 32'h7, 32'h0, 32'h0, 32'h0));
        for (int p = 0; p < 4; p++) begin
            e = exp_norm(5'h16, 32'h7, 32'h0, 32'h0, 32'h0);
            for (int j = 0; j < 12; j++) begin
                wr(6'(12 + j), {24'h000000, base[j + p[1]] | {p[0], 7'h00}});
                e[4 + j] = src_val(base[j + p[1]] | {p[0], 7'h00});
            end
            settle;
            rd(IDX_INPUT_WORD, e);
        end
        // interlock routed from input 4
        wr(6'h0b, 32'h0000_0004);
        wr(IDX_SF_ENABLE, 32'h0000_000f);
        want_phys <= 5'h06;
        settle;
        chk("interlock_fault", 32'h1, {31'h0, interlock_fault});
        chk("fault_pulses", 32'h1, 32'(pulse_cnt));
        want_phys <= 5'h0e;
        settle;
        chk("interlock_fault", 32'h0, {31'h0, interlock_fault});
        wr(IDX_SF_ENABLE, 32'h0000_0007);
        want_phys <= 5'h06;
        settle;
        chk("interlock_fault", 32'h0, {31'h0, interlock_fault});
        chk("fault_pulses", 32'h1, 32'(pulse_cnt));
        repeat (4) @(posedge clock);
        tally_and_finish;
    end
endmodule
`default_nettype wire
